// ===== hw/otpb_params.svh
// Purpose: Constants for the fuse burn and verify block
// Assumes: 250 MHz reference clock
// Notes: Offsets are byte addresses on the plain register port
`ifndef OTPB_PARAMS_SVH
`define OTPB_PARAMS_SVH
`define OTPB_CFG_FIRST 8'h0a
`define OTPB_SIG_OFS 8'h1e
`define OTPB_CTRL_OFS 8'h23
`define OTPB_KEY1_OFS 8'h62
`define OTPB_KEY2_OFS 8'h63
`define OTPB_ANGLE_LO_OFS 8'h24
`define OTPB_ANGLE_HI_OFS 8'h25
`define OTPB_STATUS_OFS 8'h26
`define OTPB_CTRL_DSP_RST 8'h20
`define OTPB_CTRL_GUARD 8'h40
`define OTPB_CTRL_NORMAL 8'h00
`define OTPB_KEY1_VAL 8'h70
`define OTPB_KEY2_VAL 8'h51
`define OTPB_LOCK_OFS 8'h0a
`define OTPB_LOCK_BIT 7
`define OTPB_CLK_MHZ 250
`define OTPB_BURN_US 10000
`define OTPB_REFRESH_US 5000
`define OTPB_BURN_CYC (`OTPB_BURN_US * `OTPB_CLK_MHZ)
`define OTPB_REFRESH_CYC (`OTPB_REFRESH_US * `OTPB_CLK_MHZ)
`endif

// ===== hw/otpb_pkg.sv
// Purpose: Types for the fuse burn and verify block
// Assumes: Nothing beyond the params header
// Notes: One-hot sequencer states
package otpb_pkg;
   typedef enum logic [3:0] {
      OTPB_IDLE = 4'b0001,
      OTPB_ARMED = 4'b0010,
      OTPB_BURN = 4'b0100,
      OTPB_REFRESH = 4'b1000
   } otpb_state_t;
endpackage : otpb_pkg

// ===== hw/otpb_mem.sv
// Purpose: Register image and fuse array storage
// Assumes: One write port per array, registered read
// Notes: Fuse array only ever gains ones, as real fuses do
`timescale 1ns/10ps
`default_nettype none
module otpb_mem #(
   parameter int DEPTH = 32,
   parameter int AW = 5
) (
   // Clock
   input wire logic ref_clk_in,
   // Image port
   input wire logic img_we_in,
   input wire logic [AW-1:0] img_addr_in,
   input wire logic [7:0] img_wdata_in,
   output logic [7:0] img_rdata_out,
   // Fuse port
   input wire logic fuse_we_in,
   input wire logic [AW-1:0] fuse_addr_in,
   input wire logic [7:0] fuse_wdata_in,
   output logic [7:0] fuse_rdata_out
);
   logic [7:0] img_mem [DEPTH];
   // Blank fuses read as zero; they start defined so the boot copy does too
   logic [7:0] fuse_mem [DEPTH] = '{default: 8'h00};

   always_ff @(posedge ref_clk_in)
   begin
      if (img_we_in)
      begin
         img_mem[img_addr_in] <= img_wdata_in;
      end
      img_rdata_out <= img_mem[img_addr_in];
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (fuse_we_in)
      begin
         fuse_mem[fuse_addr_in] <= fuse_mem[fuse_addr_in] | fuse_wdata_in;
      end
      fuse_rdata_out <= fuse_mem[fuse_addr_in];
   end
endmodule : otpb_mem
`default_nettype wire

// ===== hw/otpb_top.sv
// Purpose: Fuse burn, guard-band refresh and lock-mode control of a sensor
// Assumes: Single clock, synchronous register port, fuses start blank
// Notes: Register image 0x00..0x1f lives in otpb_mem
// Operation
// R1 - Programmer resets the processor by writing 0x20 to control before sampling
// R2 - Measured angle readable; programmer samples it at start and stop
// R3 - Programmer writes config range 0x0a..0x1e and verifies readback
// R4 - Programmer rewrites range with customer lock bit set
// R5 - Programmer reads 0x00..0x1d and computes the signature
// R6 - Programmer stores signature at 0x1e
// R7 - Programmer writes final image, verifies, then burns
// R8 - Burn starts on key 0x70 at 0x62 then 0x51 at 0x63
// R9 - Burn finishes within 10 ms; programmer waits meanwhile
// R10 - Programmer clears signature register before each refresh
// R11 - Writing 0x40 to control selects the guard-band threshold
// R12 - Image reloads from fuses within 5 ms of threshold write
// R13 - Programmer checks signature then whole range after refresh
// R14 - Failed verification means the part must not be reprogrammed
// R15 - Writing 0x00 to control restores normal threshold and refreshes
// R16 - Locked part starts in functional mode after reset
// R17 - Guard-band threshold only for verifying fresh fuses
// R18 - Unlocked part starts in communication mode
// R19 - Signature: shift left, xor byte, xor 29 if old top bit set
// R20 - Burn keys ignored outside communication mode or out of order
`timescale 1ns/10ps
`default_nettype none
`include "otpb_params.svh"
module otpb_top
   import otpb_pkg::*;
#(
   parameter int BURN_CYC = `OTPB_BURN_CYC,
   parameter int REFRESH_CYC = `OTPB_REFRESH_CYC,
   parameter int ANGLE_W = 14
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   // Sensor side
   input wire logic [ANGLE_W-1:0] measured_angle_in,
   output logic dsp_reset_out,
   output logic guard_band_out,
   output logic comm_mode_out,
   output logic busy_out
);
   localparam int AW = 5;
   localparam int WORDS = 32;

   otpb_state_t state_reg;
   logic [7:0] ctrl_reg;
   logic [31:0] timer_reg;
   logic [AW:0] copy_idx_reg;
   logic comm_mode_reg;
   logic boot_reg;
   logic burned_reg;
   logic rd_pend_reg;
   logic [7:0] rd_addr_reg;
   logic [ANGLE_W-1:0] angle_reg;

   logic img_we;
   logic [AW-1:0] img_addr;
   logic [7:0] img_wdata;
   logic [7:0] img_rdata;
   logic fuse_we;
   logic [AW-1:0] fuse_addr;
   logic [7:0] fuse_rdata;

   function automatic logic in_image(input logic [7:0] a);
      in_image = (a < 8'(WORDS));
   endfunction : in_image

   wire logic copying = (state_reg == OTPB_BURN) || (state_reg == OTPB_REFRESH);
   wire logic bus_img_wr = wr_in && in_image(addr_in) && comm_mode_reg && !copying;
   // Copy stream has one cycle of read latency, so lagged index writes
   wire logic [AW-1:0] lag_idx = copy_idx_reg[AW-1:0] - 5'h01;
   wire logic lag_valid = copying && (copy_idx_reg != '0) && (copy_idx_reg <= 6'(WORDS));

   always_comb
   begin
      img_we = bus_img_wr;
      img_addr = addr_in[AW-1:0];
      img_wdata = wdata_in;
      fuse_we = 1'b0;
      fuse_addr = copy_idx_reg[AW-1:0];
      if (state_reg == OTPB_BURN)
      begin
         img_we = 1'b0;
         img_addr = copy_idx_reg[AW-1:0];
         fuse_we = lag_valid; // [R8]
         fuse_addr = lag_valid ? lag_idx : copy_idx_reg[AW-1:0];
      end
      else if (state_reg == OTPB_REFRESH || boot_reg)
      begin
         img_we = lag_valid; // [R12]
         img_addr = lag_idx;
         img_wdata = fuse_rdata;
      end
   end

   otpb_mem #(.DEPTH(WORDS), .AW(AW)) u_mem (
      .ref_clk_in(ref_clk_in),
      .img_we_in(img_we),
      .img_addr_in(img_addr),
      .img_wdata_in(img_wdata),
      .img_rdata_out(img_rdata),
      .fuse_we_in(fuse_we),
      .fuse_addr_in(fuse_addr),
      .fuse_wdata_in(img_rdata),
      .fuse_rdata_out(fuse_rdata)
   );

   // Sequencer: keys, burn and refresh timing
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= OTPB_REFRESH;
         timer_reg <= 32'h0;
         copy_idx_reg <= '0;
         burned_reg <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            OTPB_IDLE:
            begin
               if (wr_in && comm_mode_reg && addr_in == `OTPB_KEY1_OFS
                   && wdata_in == `OTPB_KEY1_VAL)
               begin
                  state_reg <= OTPB_ARMED; // [R20]
               end
               else if (wr_in && comm_mode_reg && addr_in == `OTPB_CTRL_OFS
                        && (wdata_in == `OTPB_CTRL_GUARD || wdata_in == `OTPB_CTRL_NORMAL))
               begin
                  state_reg <= OTPB_REFRESH; // [R11] [R15]
                  timer_reg <= 32'h0;
                  copy_idx_reg <= '0;
               end
            end
            OTPB_ARMED:
            begin
               if (wr_in)
               begin
                  if (addr_in == `OTPB_KEY2_OFS && wdata_in == `OTPB_KEY2_VAL
                      && !burned_reg)
                  begin
                     state_reg <= OTPB_BURN; // [R8]
                     timer_reg <= 32'h0;
                     copy_idx_reg <= '0;
                  end
                  else
                  begin
                     state_reg <= OTPB_IDLE; // [R20]
                  end
               end
            end
            OTPB_BURN, OTPB_REFRESH:
            begin
               if (!copy_idx_reg[AW] || !copy_idx_reg[0]) // Park at WORDS+1, past last lag
               begin
                  copy_idx_reg <= copy_idx_reg + 6'h01;
               end
               timer_reg <= timer_reg + 32'h1;
               if (timer_reg >= 32'(((state_reg == OTPB_BURN) ? BURN_CYC : REFRESH_CYC) - 1))
               begin
                  state_reg <= OTPB_IDLE; // [R9] [R12]
                  if (state_reg == OTPB_BURN)
                  begin
                     burned_reg <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   // Boot refresh follows reset; mode is taken from lock bit as that byte is copied
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         boot_reg <= 1'b1;
         comm_mode_reg <= 1'b0;
      end
      else if (boot_reg && lag_valid && lag_idx == AW'(`OTPB_LOCK_OFS))
      begin
         comm_mode_reg <= !fuse_rdata[`OTPB_LOCK_BIT]; // [R16] [R18]
      end
      else if (boot_reg && state_reg == OTPB_IDLE)
      begin
         boot_reg <= 1'b0;
      end
   end

   // Control register drives processor reset and fuse threshold
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         ctrl_reg <= 8'h00;
      end
      else if (wr_in && comm_mode_reg && addr_in == `OTPB_CTRL_OFS && state_reg == OTPB_IDLE)
      begin
         ctrl_reg <= wdata_in; // [R1] [R11] [R15]
      end
      else if (ctrl_reg == `OTPB_CTRL_DSP_RST)
      begin
         ctrl_reg <= 8'h00; // Processor reset is a one-cycle pulse
      end
   end

   // Angle latched every cycle except during a low byte read strobe, which holds it for that read
   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         angle_reg <= '0;
      end
      else if (!(rd_in && addr_in == `OTPB_ANGLE_LO_OFS))
      begin
         angle_reg <= measured_angle_in; // [R2]
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         rd_pend_reg <= 1'b0;
         rd_addr_reg <= 8'h00;
      end
      else
      begin
         rd_pend_reg <= rd_in;
         rd_addr_reg <= addr_in;
      end
   end

   // Read data valid only in cycle after strobe; unmapped reads zero
   always_comb
   begin
      rdata_out = 8'h00;
      if (rd_pend_reg)
      begin
         if (in_image(rd_addr_reg))
         begin
            rdata_out = img_rdata;
         end
         else
         begin
            unique case (rd_addr_reg)
               `OTPB_CTRL_OFS: rdata_out = ctrl_reg;
               `OTPB_ANGLE_LO_OFS: rdata_out = angle_reg[7:0]; // [R2]
               `OTPB_ANGLE_HI_OFS: rdata_out = 8'(angle_reg[ANGLE_W-1:8]);
               `OTPB_STATUS_OFS: rdata_out = {4'h0, burned_reg, busy_out, comm_mode_reg,
                                              boot_reg};
               default: rdata_out = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (!rst_n_in)
      begin
         dsp_reset_out <= 1'b0;
         guard_band_out <= 1'b0;
         comm_mode_out <= 1'b0;
         busy_out <= 1'b1;
      end
      else
      begin
         dsp_reset_out <= (ctrl_reg == `OTPB_CTRL_DSP_RST); // [R1]
         guard_band_out <= (ctrl_reg == `OTPB_CTRL_GUARD); // [R11]
         comm_mode_out <= comm_mode_reg;
         busy_out <= copying;
      end
   end

   chk_burn_keys_order: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R20]
      (state_reg == OTPB_BURN && $past(state_reg) != OTPB_BURN) |->
      $past(state_reg) == OTPB_ARMED)
      else $error("Burn started without first key");
   chk_burn_bounded: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R9]
      state_reg == OTPB_BURN |-> timer_reg < 32'(BURN_CYC)) else $error("Burn overran");
   chk_refresh_bounded: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R12]
      state_reg == OTPB_REFRESH |-> timer_reg < 32'(REFRESH_CYC)) else $error("Refresh overran");
   chk_guard_output: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R11]
      ctrl_reg == `OTPB_CTRL_GUARD |=> guard_band_out) else $error("Guard band not selected");
   chk_dsp_reset_issued: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R1]
      ctrl_reg == `OTPB_CTRL_DSP_RST |=> dsp_reset_out) else $error("Processor reset missing");
   chk_locked_no_arm: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in) // [R20]
      !comm_mode_reg |-> state_reg != OTPB_ARMED) else $error("Key taken while locked");
endmodule : otpb_top
`default_nettype wire

// ===== bench/otpb_prog_model.sv
// Purpose: Programmer model on the far side of the register port
// Assumes: Device never stalls the port
// Notes: Released lines show inverted values, never stale ones
`timescale 1ns/10ps
`default_nettype none
module otpb_prog_model (
   // Clock
   input wire logic ref_clk_in,
   // Register port
   output logic [7:0] addr_out,
   output logic [7:0] wdata_out,
   output logic wr_out,
   output logic rd_out
);
   initial
   begin
      addr_out = 8'h00;
      wdata_out = 8'h00;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge ref_clk_in);
      wr_out <= 1'b0;
      addr_out <= ~a;
      wdata_out <= ~d;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      @(posedge ref_clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge ref_clk_in);
      rd_out <= 1'b0;
      addr_out <= ~a;
   endtask : rd_reg
   // Signature over image bytes 0x00..0x1d
   function automatic logic [7:0] signature(input logic [7:0] img [0:31]);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 30; i++)
         m = ({m[6:0], 1'b0} ^ img[i]) ^ (m[7] ? 8'h1d : 8'h00);
      return m;
   endfunction : signature
endmodule : otpb_prog_model
`default_nettype wire

// ===== bench/otpb_top_tb.sv
// Purpose: Self-checking bench for the fuse burn and verify block
// Assumes: Fuses blank at start, short burn and refresh counts
// Notes: Reads are checked from a queue of expected bytes
`timescale 1ns/10ps
`default_nettype none
`include "otpb_params.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR %s exp %h got %h", n, e, g); end end
module otpb_top_tb;
   import otpb_pkg::*;
   localparam int BURN = 100;
   localparam int REFR = 80;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [13:0] measured_angle_in = 14'h0000;
   logic [7:0] addr, wdata, rdata_out, e_v, sig;
   logic wr, rd, dsp_reset_out, guard_band_out, comm_mode_out, busy_out;
   logic rd_d = 1'b0;
   logic [7:0] img [0:31];
   logic [7:0] exp_q [$];
   logic [7:0] thr [0:1] = '{8'h40, 8'h00};
   int err_count = 0;
   int comparisons = 0;
   int seed = 29;
   always #2 ref_clk_in = ~ref_clk_in;
   otpb_top #(.BURN_CYC(BURN), .REFRESH_CYC(REFR)) dut (.ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
      .rdata_out(rdata_out), .measured_angle_in(measured_angle_in),
      .dsp_reset_out(dsp_reset_out), .guard_band_out(guard_band_out),
      .comm_mode_out(comm_mode_out), .busy_out(busy_out));
   otpb_prog_model prog (.ref_clk_in(ref_clk_in), .addr_out(addr), .wdata_out(wdata),
      .wr_out(wr), .rd_out(rd));
   // Read data stands only in the cycle after the strobe
   always @(posedge ref_clk_in) rd_d <= rd;
   always @(negedge ref_clk_in)
      if (rd_d === 1'b1)
      begin
         `CHK("read pending", 1'b1, exp_q.size() > 0)
         e_v = (exp_q.size() > 0) ? exp_q.pop_front() : 8'h00;
         `CHK("read data", e_v, rdata_out)
      end
   task automatic give_verdict;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      prog.rd_reg(a);
   endtask : rd_chk
   task automatic rd_range(input int lo, input int hi);
      for (int a = lo; a <= hi; a++)
         rd_chk(8'(a), img[a]);
   endtask : rd_range
   task automatic wait_busy(input logic lvl, input int n);
      int i;
      i = 0;
      while (busy_out !== lvl && i < n)
      begin
         @(posedge ref_clk_in);
         #1;
         i++;
      end
      `CHK("busy", lvl, busy_out)
      if (busy_out !== lvl)
         give_verdict();
   endtask : wait_busy
   task automatic burn_keys(input logic gap);
      prog.wr_reg(`OTPB_KEY1_OFS, `OTPB_KEY1_VAL);
      if (gap)
         prog.wr_reg(8'h0b, img[11]);
      prog.wr_reg(`OTPB_KEY2_OFS, `OTPB_KEY2_VAL);
   endtask : burn_keys
   task automatic no_burn;
      repeat (4) @(posedge ref_clk_in);
      #1 `CHK("busy idle", 1'b0, busy_out)
   endtask : no_burn
   task automatic do_reset;
      rst_n_in <= 1'b0;
      repeat (6) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      wait_busy(1'b0, REFR + 20);
   endtask : do_reset
   initial
   begin
      for (int a = 0; a < 32; a++)
         img[a] = 8'h00;
      do_reset();
      `CHK("comm mode", 1'b1, comm_mode_out)
      rd_chk(`OTPB_STATUS_OFS, 8'h02);
      prog.wr_reg(`OTPB_CTRL_OFS, `OTPB_CTRL_DSP_RST);
      @(posedge ref_clk_in);
      #1 `CHK("dsp reset", 1'b1, dsp_reset_out)
      @(posedge ref_clk_in);
      #1 `CHK("dsp reset end", 1'b0, dsp_reset_out)
      // Start and stop calibration points
      repeat (2)
      begin
         @(posedge ref_clk_in);
         measured_angle_in <= 14'($random(seed));
         @(posedge ref_clk_in);
         rd_chk(`OTPB_ANGLE_LO_OFS, measured_angle_in[7:0]);
         rd_chk(`OTPB_ANGLE_HI_OFS, {2'b00, measured_angle_in[13:8]});
      end
      rd_chk(8'h40, 8'h00);
      for (int a = 10; a <= 29; a++)
         img[a] = 8'($random(seed));
      img[10][`OTPB_LOCK_BIT] = 1'b1;
      for (int a = 10; a <= 29; a++)
         prog.wr_reg(8'(a), img[a]);
      rd_range(0, 29);
      sig = prog.signature(img);
      img[30] = sig;
      prog.wr_reg(`OTPB_SIG_OFS, sig);
      rd_range(10, 30);
      // Lone second key, then a key pair broken by another write
      prog.wr_reg(`OTPB_KEY2_OFS, `OTPB_KEY2_VAL);
      no_burn();
      burn_keys(1'b1);
      no_burn();
      burn_keys(1'b0);
      wait_busy(1'b1, 4);
      wait_busy(1'b0, BURN + 10);
      rd_chk(`OTPB_STATUS_OFS, 8'h0a);
      // Guard band only here, on freshly burned fuses
      for (int p = 0; p < 2; p++)
      begin
         prog.wr_reg(`OTPB_SIG_OFS, 8'h00);
         prog.wr_reg(`OTPB_CTRL_OFS, thr[p]);
         wait_busy(1'b1, 4);
         wait_busy(1'b0, REFR + 10);
         `CHK("guard band", thr[p] == 8'h40, guard_band_out)
         rd_chk(`OTPB_CTRL_OFS, thr[p]);
         rd_chk(`OTPB_SIG_OFS, sig);
         rd_range(10, 30);
         repeat (3) @(posedge ref_clk_in);
         if (err_count != 0)
            give_verdict();
      end
      // A burned part must refuse a second burn
      burn_keys(1'b0);
      no_burn();
      do_reset();
      `CHK("locked mode", 1'b0, comm_mode_out)
      prog.wr_reg(8'h0b, ~img[11]);
      rd_chk(8'h0b, img[11]);
      burn_keys(1'b0);
      no_burn();
      repeat (3) @(posedge ref_clk_in);
      give_verdict();
   end
endmodule : otpb_top_tb
`default_nettype wire
